// file: logic/sleep_cfg_pkg.sv
/*
 * Constants for the sleep policy and serial port configuration register group:
 * register offsets, field positions, power-on default contents and state codes.
 * Assumes the register group sits behind the serial port front-end, which
 * delivers decoded byte accesses on the device clock.
 */
// Overview of operation
// - scaling port address from selector, base 0010010
// - general port address from selector, base 0101101
// - power-on reset reloads programmed default contents
// - buck bit selects general or scaling port
// - stay-active 0 with switch-off 0 gives eco, stay-active 1 full in sleep
// - switch-off 1 with stay-active 0 turns off
// - sleep needs permit bit and no pending switch-off
package sleep_cfg_pkg;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0] OFS_SERIAL_PORT_CONFIG = 8'h26;
    localparam logic [7:0] OFS_SLEEP_HOLD_LINEAR_LOW = 8'h27;
    localparam logic [7:0] OFS_SLEEP_HOLD_BUCK_LINEAR_HIGH = 8'h28;
    localparam logic [7:0] OFS_SLEEP_SWITCH_OFF_LINEAR_LOW = 8'h29;

    // ****************************************************************
    // field layout
    // ****************************************************************
    localparam int SCALING_SEL_LSB = 6;
    localparam int GENERAL_SEL_LSB = 4;
    localparam logic [7:0] CFG_WRITABLE_MASK = 8'h0F;
    localparam logic [7:0] HOLD_HIGH_WRITABLE_MASK = 8'h3F;
    localparam int NUM_LINEAR = 10;
    localparam int NUM_BUCK = 4;
    localparam int NUM_REGULATORS = 14;
    localparam int NUM_SWITCH_OFF = 8;

    // ****************************************************************
    // target address bases for the two serial ports
    // ****************************************************************
    localparam logic [6:0] SCALING_ADDR_BASE = 7'h12;
    localparam logic [6:0] GENERAL_ADDR_BASE = 7'h2D;

    // ****************************************************************
    // power-on default contents (programmed image)
    // ****************************************************************
    localparam logic [7:0] RST_SERIAL_PORT_CONFIG = 8'h40;
    localparam logic [7:0] RST_SLEEP_HOLD_LINEAR_LOW = 8'hE6;
    localparam logic [7:0] RST_SLEEP_HOLD_BUCK_LINEAR_HIGH = 8'h3B;
    localparam logic [7:0] RST_SLEEP_SWITCH_OFF_LINEAR_LOW = 8'h19;
    localparam logic [7:0] RST_READ_DATA = 8'h00;

    // ****************************************************************
    // device power state
    // ****************************************************************
    typedef enum logic [0:0] {
        ST_ACTIVE = 1'b0,
        ST_SLEEP = 1'b1
    } power_state_e;

endpackage : sleep_cfg_pkg

// file: logic/sleep_policy.sv
/*
 * Per-regulator sleep mode decode: turns the stay-active and switch-off bits
 * into registered eco and off controls while the device is asleep.
 * Assumes all inputs come from logic on the same clock.
 */
`timescale 1ns/1ps
module sleep_policy (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_sleep,
    input wire logic [sleep_cfg_pkg::NUM_REGULATORS-1:0] stay_active,
    input wire logic [sleep_cfg_pkg::NUM_REGULATORS-1:0] switch_off,
    output logic [sleep_cfg_pkg::NUM_REGULATORS-1:0] eco_mode,
    output logic [sleep_cfg_pkg::NUM_REGULATORS-1:0] turned_off
);

    // ****************************************************************
    // one decode per regulator
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < sleep_cfg_pkg::NUM_REGULATORS; i++) begin : g_reg
            logic eco_q;
            logic off_q;
            always_ff @(posedge clk) begin
                if (rst) begin
                    eco_q <= 1'b0;
                    off_q <= 1'b0;
                end else begin
                    // stay-active wins; otherwise switch-off picks off over eco
                    eco_q <= in_sleep & ~stay_active[i] & ~switch_off[i];
                    off_q <= in_sleep & ~stay_active[i] & switch_off[i];
                end
            end
            assign eco_mode[i] = eco_q;
            assign turned_off[i] = off_q;
        end
    endgenerate

endmodule : sleep_policy

// file: logic/sleep_port_cfg_regs.sv
/*
 * Sleep policy and serial port configuration register group: four byte
 * registers, port target addresses, buck port assignment and the sleep state.
 * Assumes the serial port front-end presents byte accesses synchronous to CLK
 * and that RST is the power-on reset; SLEEP_REQ comes from a pin.
 */
`timescale 1ns/1ps
module sleep_port_cfg_regs (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    output logic REG_RACK,
    input wire logic SLEEP_PERMIT,
    input wire logic SWITCH_OFF_PENDING,
    input wire logic SLEEP_REQ,
    output logic IN_SLEEP,
    output logic [6:0] SCALING_PORT_ADDR,
    output logic [6:0] GENERAL_PORT_ADDR,
    output logic [3:0] BUCK_PORT_ASSIGN,
    output logic [13:0] REG_SLEEP_ECO,
    output logic [13:0] REG_SLEEP_OFF
);

    // ****************************************************************
    // register storage
    // ****************************************************************
    logic [7:0] cfg_q;
    logic [7:0] hold_low_q;
    logic [7:0] hold_high_q;
    logic [7:0] off_low_q;
    logic [7:0] rdata_q;
    logic rack_q;
    logic [6:0] scal_addr_q;
    logic [6:0] gen_addr_q;
    logic req_meta_q;
    logic req_sync_q;
    sleep_cfg_pkg::power_state_e state_q;
    sleep_cfg_pkg::power_state_e state_d;
    logic [13:0] stay_vec;
    logic [13:0] off_vec;
    logic sel_cfg;
    logic sel_hold_low;
    logic sel_hold_high;
    logic sel_off_low;

    assign sel_cfg = REG_ADDR == sleep_cfg_pkg::OFS_SERIAL_PORT_CONFIG;
    assign sel_hold_low = REG_ADDR == sleep_cfg_pkg::OFS_SLEEP_HOLD_LINEAR_LOW;
    assign sel_hold_high = REG_ADDR == sleep_cfg_pkg::OFS_SLEEP_HOLD_BUCK_LINEAR_HIGH;
    assign sel_off_low = REG_ADDR == sleep_cfg_pkg::OFS_SLEEP_SWITCH_OFF_LINEAR_LOW;

    // ****************************************************************
    // writes
    // ****************************************************************
    always_ff @(posedge CLK) begin
        if (RST) begin
            cfg_q <= sleep_cfg_pkg::RST_SERIAL_PORT_CONFIG;
        end else if (REG_WR && sel_cfg) begin
            // selector bits keep their programmed value
            cfg_q <= (cfg_q & ~sleep_cfg_pkg::CFG_WRITABLE_MASK)
                   | (REG_WDATA & sleep_cfg_pkg::CFG_WRITABLE_MASK);
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            hold_low_q <= sleep_cfg_pkg::RST_SLEEP_HOLD_LINEAR_LOW;
        end else if (REG_WR && sel_hold_low) begin
            hold_low_q <= REG_WDATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            hold_high_q <= sleep_cfg_pkg::RST_SLEEP_HOLD_BUCK_LINEAR_HIGH;
        end else if (REG_WR && sel_hold_high) begin
            hold_high_q <= REG_WDATA & sleep_cfg_pkg::HOLD_HIGH_WRITABLE_MASK;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            off_low_q <= sleep_cfg_pkg::RST_SLEEP_SWITCH_OFF_LINEAR_LOW;
        end else if (REG_WR && sel_off_low) begin
            off_low_q <= REG_WDATA;
        end
    end

    // ****************************************************************
    // reads: data one cycle after the strobe, unmapped reads zero
    // ****************************************************************
    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata_q <= sleep_cfg_pkg::RST_READ_DATA;
            rack_q <= 1'b0;
        end else begin
            rack_q <= REG_RD;
            if (REG_RD) begin
                if (sel_cfg) begin
                    rdata_q <= cfg_q;
                end else if (sel_hold_low) begin
                    rdata_q <= hold_low_q;
                end else if (sel_hold_high) begin
                    rdata_q <= hold_high_q & sleep_cfg_pkg::HOLD_HIGH_WRITABLE_MASK;
                end else if (sel_off_low) begin
                    rdata_q <= off_low_q;
                end else begin
                    rdata_q <= sleep_cfg_pkg::RST_READ_DATA;
                end
            end
        end
    end

    assign REG_RDATA = rdata_q;
    assign REG_RACK = rack_q;

    // ****************************************************************
    // serial port target addresses and buck assignment
    // ****************************************************************
    always_ff @(posedge CLK) begin
        if (RST) begin
            scal_addr_q <= sleep_cfg_pkg::SCALING_ADDR_BASE;
            gen_addr_q <= sleep_cfg_pkg::GENERAL_ADDR_BASE;
        end else begin
            scal_addr_q <= sleep_cfg_pkg::SCALING_ADDR_BASE
                         + {5'h00, cfg_q[sleep_cfg_pkg::SCALING_SEL_LSB +: 2]};
            gen_addr_q <= sleep_cfg_pkg::GENERAL_ADDR_BASE
                        + {5'h00, cfg_q[sleep_cfg_pkg::GENERAL_SEL_LSB +: 2]};
        end
    end

    assign SCALING_PORT_ADDR = scal_addr_q;
    assign GENERAL_PORT_ADDR = gen_addr_q;
    // 0 routes the buck voltage registers to the general port, 1 to scaling
    assign BUCK_PORT_ASSIGN = cfg_q[3:0];

    // ****************************************************************
    // sleep state
    // ****************************************************************
    always_ff @(posedge CLK) begin
        if (RST) begin
            req_meta_q <= 1'b0;
            req_sync_q <= 1'b0;
        end else begin
            req_meta_q <= SLEEP_REQ;
            req_sync_q <= req_meta_q;
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            sleep_cfg_pkg::ST_ACTIVE: begin
                if (req_sync_q && SLEEP_PERMIT && !SWITCH_OFF_PENDING) begin
                    state_d = sleep_cfg_pkg::ST_SLEEP;
                end
            end
            sleep_cfg_pkg::ST_SLEEP: begin
                if (!req_sync_q || !SLEEP_PERMIT || SWITCH_OFF_PENDING) begin
                    state_d = sleep_cfg_pkg::ST_ACTIVE;
                end
            end
            default: begin
                state_d = sleep_cfg_pkg::ST_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_q <= sleep_cfg_pkg::ST_ACTIVE;
        end else begin
            state_q <= state_d;
        end
    end

    assign IN_SLEEP = state_q == sleep_cfg_pkg::ST_SLEEP;

    // ****************************************************************
    // per-regulator sleep mode
    // ****************************************************************
    assign stay_vec = {hold_high_q[5:0], hold_low_q};
    assign off_vec = {6'h00, off_low_q};

    sleep_policy u_policy (
        .clk(CLK),
        .rst(RST),
        .in_sleep(IN_SLEEP),
        .stay_active(stay_vec),
        .switch_off(off_vec),
        .eco_mode(REG_SLEEP_ECO),
        .turned_off(REG_SLEEP_OFF)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    // the edge that releases reset still loads the bare base, so start one edge later
    chk_scaling_addr_map: assert property (@(posedge CLK) disable iff (RST)
        !RST |=> SCALING_PORT_ADDR
            == sleep_cfg_pkg::SCALING_ADDR_BASE + {5'h00, $past(cfg_q[7:6])})
        else $error("scaling port address does not follow selector");

    chk_general_addr_map: assert property (@(posedge CLK) disable iff (RST)
        !RST |=> GENERAL_PORT_ADDR
            == sleep_cfg_pkg::GENERAL_ADDR_BASE + {5'h00, $past(cfg_q[5:4])})
        else $error("general port address does not follow selector");

    chk_reset_defaults: assert property (@(posedge CLK)
        RST |=> (cfg_q == 8'h40 && hold_low_q == 8'hE6 && hold_high_q == 8'h3B
                 && off_low_q == 8'h19))
        else $error("registers not at defaults after reset");

    chk_buck_assign_write: assert property (@(posedge CLK) disable iff (RST)
        (REG_WR && REG_ADDR == 8'h26) |=> BUCK_PORT_ASSIGN == $past(REG_WDATA[3:0]))
        else $error("buck port assignment not updated by write");

    chk_stay_active_full: assert property (@(posedge CLK) disable iff (RST)
        ##1 (REG_SLEEP_ECO == ($past(IN_SLEEP) ? ($past(~stay_vec & ~off_vec)) : 14'h0000)))
        else $error("eco control does not match stay-active setting");

    chk_switch_off_sleep: assert property (@(posedge CLK) disable iff (RST)
        ##1 (REG_SLEEP_OFF == ($past(IN_SLEEP) ? ($past(~stay_vec & off_vec)) : 14'h0000)))
        else $error("off control does not match switch-off setting");

    chk_sleep_entry_cond: assert property (@(posedge CLK) disable iff (RST)
        (!IN_SLEEP ##1 IN_SLEEP) |-> $past(SLEEP_PERMIT && !SWITCH_OFF_PENDING && req_sync_q))
        else $error("sleep entered without permit or with switch-off pending");

    chk_sleep_exit_pending: assert property (@(posedge CLK) disable iff (RST)
        (IN_SLEEP && SWITCH_OFF_PENDING) |=> !IN_SLEEP)
        else $error("sleep kept while switch-off pending");

    chk_selector_readonly: assert property (@(posedge CLK) disable iff (RST)
        (REG_WR && REG_ADDR == 8'h26) |=> cfg_q[7:4] == $past(cfg_q[7:4]))
        else $error("address selector changed by write");

    chk_reserved_read_zero: assert property (@(posedge CLK) disable iff (RST)
        (REG_RD && REG_ADDR == 8'h28) |=> (REG_RACK && REG_RDATA[7:6] == 2'b00))
        else $error("reserved bits read nonzero");

endmodule : sleep_port_cfg_regs

// file: bench/host_model.sv
/*
 * Host side of the register port: issues one-cycle write and read strobes
 * and notes each expected read value in a queue for the bench's watcher.
 * Assumes the bench samples the queue on the same clock as the design.
 */
`timescale 1ns/1ps
module host_model (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd
);
    logic [7:0] exp_q [$];

    initial begin
        reg_addr = 8'hA5;
        reg_wr = 1'b0;
        reg_wdata = 8'h5A;
        reg_rd = 1'b0;
    end

    // released lines show the inverse of the last value
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        exp_q.push_back(e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
    endtask : rd_reg
endmodule : host_model

// file: bench/tb_sleep_port_cfg_regs.sv
/*
 * Self-checking bench for the sleep policy and port configuration registers.
 * Assumes the host model drives the register port and the bench the sleep inputs.
 */
`timescale 1ns/1ps
module tb_sleep_port_cfg_regs;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic SLEEP_PERMIT = 1'b0;
    logic SWITCH_OFF_PENDING = 1'b0;
    logic SLEEP_REQ = 1'b0;
    logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
    logic REG_WR, REG_RD, REG_RACK, IN_SLEEP;
    logic [6:0] SCALING_PORT_ADDR, GENERAL_PORT_ADDR;
    logic [3:0] BUCK_PORT_ASSIGN;
    logic [13:0] REG_SLEEP_ECO, REG_SLEEP_OFF;
    logic [7:0] bad_addr [4] = '{8'h00, 8'h2A, 8'h25, 8'hFF};
    int fail_count = 0;
    int n_checks = 0;

    always #2.5 CLK = ~CLK;

    host_model host (.clk(CLK), .reg_addr(REG_ADDR), .reg_wr(REG_WR),
        .reg_wdata(REG_WDATA), .reg_rd(REG_RD));

    sleep_port_cfg_regs dut (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
        .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RACK(REG_RACK),
        .SLEEP_PERMIT(SLEEP_PERMIT), .SWITCH_OFF_PENDING(SWITCH_OFF_PENDING),
        .SLEEP_REQ(SLEEP_REQ), .IN_SLEEP(IN_SLEEP), .SCALING_PORT_ADDR(SCALING_PORT_ADDR),
        .GENERAL_PORT_ADDR(GENERAL_PORT_ADDR), .BUCK_PORT_ASSIGN(BUCK_PORT_ASSIGN),
        .REG_SLEEP_ECO(REG_SLEEP_ECO), .REG_SLEEP_OFF(REG_SLEEP_OFF));

    // ****************************************************************
    // comparison and verdict
    // ****************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic end_of_test();
        if (fail_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    // read answers are matched against the oldest noted value
    always @(negedge CLK) begin
        if (REG_RACK === 1'b1) begin
            if (host.exp_q.size() == 0) begin
                chk(16'h0001, 16'h0000, "answer without read");
            end else begin
                chk(16'(REG_RDATA), 16'(host.exp_q.pop_front()), "read data");
            end
        end
    end

    task automatic wait_sleep(input logic lvl);
        int i;
        for (i = 0; i < 12; i++) begin
            @(posedge CLK);
            #1;
            if (IN_SLEEP === lvl) break;
        end
        if (i == 12) begin
            fail_count++;
            $display("unexpected at %0t: sleep state wait ran out", $time);
            end_of_test();
        end
    endtask : wait_sleep

    task automatic check_defaults();
        host.rd_reg(sleep_cfg_pkg::OFS_SERIAL_PORT_CONFIG, sleep_cfg_pkg::RST_SERIAL_PORT_CONFIG);
        host.rd_reg(sleep_cfg_pkg::OFS_SLEEP_HOLD_LINEAR_LOW,
            sleep_cfg_pkg::RST_SLEEP_HOLD_LINEAR_LOW);
        host.rd_reg(sleep_cfg_pkg::OFS_SLEEP_HOLD_BUCK_LINEAR_HIGH,
            sleep_cfg_pkg::RST_SLEEP_HOLD_BUCK_LINEAR_HIGH);
        host.rd_reg(sleep_cfg_pkg::OFS_SLEEP_SWITCH_OFF_LINEAR_LOW,
            sleep_cfg_pkg::RST_SLEEP_SWITCH_OFF_LINEAR_LOW);
        #1;
        chk(16'(SCALING_PORT_ADDR), 16'h0013, "scaling port address");
        chk(16'(GENERAL_PORT_ADDR), 16'h002D, "general port address");
        chk(16'(BUCK_PORT_ASSIGN), 16'h0000, "buck port assignment");
        chk(16'(IN_SLEEP), 16'h0000, "idle sleep state");
        chk(16'(REG_SLEEP_ECO), 16'h0000, "idle eco commands");
        chk(16'(REG_SLEEP_OFF), 16'h0000, "idle off commands");
    endtask : check_defaults

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        logic [7:0] d_cfg, d_lo, d_hi, d_off;
        logic [13:0] keep14, off14;
        void'($urandom(97));
        repeat (8) @(posedge CLK);
        RST <= 1'b0;
        check_defaults();
        for (int k = 0; k < 4; k++) begin
            d_cfg = 8'($urandom);
            d_lo = 8'($urandom);
            d_hi = 8'($urandom);
            d_off = 8'($urandom);
            host.wr_reg(sleep_cfg_pkg::OFS_SERIAL_PORT_CONFIG, d_cfg);
            host.rd_reg(sleep_cfg_pkg::OFS_SERIAL_PORT_CONFIG, {4'h4, d_cfg[3:0]});
            host.wr_reg(sleep_cfg_pkg::OFS_SLEEP_HOLD_LINEAR_LOW, d_lo);
            host.wr_reg(sleep_cfg_pkg::OFS_SLEEP_HOLD_BUCK_LINEAR_HIGH, d_hi);
            host.wr_reg(sleep_cfg_pkg::OFS_SLEEP_SWITCH_OFF_LINEAR_LOW, d_off);
            host.wr_reg(bad_addr[k], d_cfg);
            host.rd_reg(sleep_cfg_pkg::OFS_SLEEP_HOLD_LINEAR_LOW, d_lo);
            host.rd_reg(sleep_cfg_pkg::OFS_SLEEP_HOLD_BUCK_LINEAR_HIGH, {2'b00, d_hi[5:0]});
            host.rd_reg(sleep_cfg_pkg::OFS_SLEEP_SWITCH_OFF_LINEAR_LOW, d_off);
            host.rd_reg(bad_addr[k], 8'h00);
            #1;
            chk(16'(BUCK_PORT_ASSIGN), 16'(d_cfg[3:0]), "buck port assignment");
            chk(16'(SCALING_PORT_ADDR), 16'h0013, "scaling port address");
            chk(16'(GENERAL_PORT_ADDR), 16'h002D, "general port address");
            keep14 = {d_hi[5:0], d_lo};
            off14 = {6'b000000, d_off};
            @(posedge CLK);
            SLEEP_PERMIT <= k[0];
            SLEEP_REQ <= 1'b1;
            if (k[0]) begin
                repeat (2) @(posedge CLK);
                #1;
                chk(16'(IN_SLEEP), 16'h0000, "sleep too early");
                @(posedge CLK);
                #1;
                chk(16'(IN_SLEEP), 16'h0001, "sleep entry");
            end else begin
                repeat (5) @(posedge CLK);
                #1;
                chk(16'(IN_SLEEP), 16'h0000, "sleep without permit");
                @(posedge CLK);
                SLEEP_PERMIT <= 1'b1;
                wait_sleep(1'b1);
            end
            repeat (2) @(posedge CLK);
            #1;
            chk(16'(REG_SLEEP_ECO), {2'b00, ~keep14 & ~off14}, "eco commands");
            chk(16'(REG_SLEEP_OFF), {2'b00, ~keep14 & off14}, "off commands");
            @(posedge CLK);
            SWITCH_OFF_PENDING <= 1'b1;
            @(posedge CLK);
            #1;
            chk(16'(IN_SLEEP), 16'h0000, "sleep with pending switch-off");
            repeat (2) @(posedge CLK);
            #1;
            chk(16'(REG_SLEEP_ECO), 16'h0000, "eco outside sleep");
            chk(16'(REG_SLEEP_OFF), 16'h0000, "off outside sleep");
            @(posedge CLK);
            SLEEP_REQ <= 1'b0;
            repeat (4) @(posedge CLK);
            SWITCH_OFF_PENDING <= 1'b0;
        end
        @(posedge CLK);
        RST <= 1'b1;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        check_defaults();
        repeat (4) @(posedge CLK);
        chk(16'(host.exp_q.size()), 16'h0000, "reads left unanswered");
        end_of_test();
    end
endmodule : tb_sleep_port_cfg_regs
